// ---- verilog/fst_dpll_ctrl.sv ----
// Purpose: pll channel state sequencing, lock flags and frequency steering
// Assumes: reference validity and lock detector inputs are on hclk
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.

module fst_dpll_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ref_valid,
  input wire logic crystal_valid,
  input wire logic acq_done,
  input wire logic freq_in_tol,
  input wire logic phase_in_tol,
  input wire logic history_valid,
  input wire logic [39:0] history_word,
  input wire logic steer_trigger_pin,
  input wire logic steer_direction_pin,
  output logic freq_lock_lost_flag,
  output logic phase_lock_lost_flag,
  output logic wide_bw_active,
  output logic history_accumulate,
  output logic ref_selected,
  output logic analog_on_crystal,
  output logic [39:0] holdover_freq_word,
  output logic [39:0] digital_numerator,
  output logic [39:0] analog_numerator
);

  localparam int unsigned NW = fst_pkg::NUM_W;
  localparam int unsigned SW = fst_pkg::STEP_W;

  // ************************************************************
  // bus slave
  // ************************************************************
  fst_pkg::fst_ahb_ap_t ap_q;
  fst_pkg::fst_state_t state_q;
  fst_pkg::fst_state_t state_d;
  logic steer_active_q;
  logic [3:0] ctrl_q;
  logic [SW-1:0] step_word_q;
  logic [NW-1:0] free_run_q;
  logic [NW-1:0] dig_base_q;
  logic [NW-1:0] ana_base_q;
  logic [NW-1:0] ana_rel_q;
  logic [31:0] lo_stage_q;
  logic wr_en;
  logic [31:0] rd_word;
  logic sw_step;
  logic fbnum_wr;
  logic [NW-1:0] wr40;

  assign wr_en = ce && ap_q.valid && ap_q.write;
  assign wr40 = {hwdata[NW-33:0], lo_stage_q};

  function automatic logic is_wr(input fst_pkg::fst_ahb_ap_t ap, input logic [7:0] ofs);
    is_wr = ap.valid && ap.write && (ap.addr == ofs);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      ap_q.valid <= hsel && hready && htrans[1];
      ap_q.write <= hwrite;
      ap_q.addr <= haddr[7:0];
      hrdata <= (hsel && hready && htrans[1] && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // read decode, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      fst_pkg::OFS_CTRL: rd_word = {28'h000_0000, ctrl_q};
      fst_pkg::OFS_STATUS: begin
        rd_word[fst_pkg::ST_STATE_LSB +: 4] = state_q;
        rd_word[fst_pkg::ST_FREQ_LOST] = freq_lock_lost_flag;
        rd_word[fst_pkg::ST_PHASE_LOST] = phase_lock_lost_flag;
        rd_word[fst_pkg::ST_WIDE_BW] = wide_bw_active;
        rd_word[fst_pkg::ST_HIST_ACC] = history_accumulate;
        rd_word[fst_pkg::ST_STEER_ACT] = steer_active_q;
        rd_word[fst_pkg::ST_REF_SEL] = ref_selected;
      end
      fst_pkg::OFS_STEP_LO: rd_word = step_word_q[31:0];
      fst_pkg::OFS_STEP_HI: rd_word = {26'h000_0000, step_word_q[SW-1:32]};
      fst_pkg::OFS_FREE_LO: rd_word = free_run_q[31:0];
      fst_pkg::OFS_FREE_HI: rd_word = {24'h00_0000, free_run_q[NW-1:32]};
      fst_pkg::OFS_FBNUM_LO: rd_word = dig_base_q[31:0];
      fst_pkg::OFS_FBNUM_HI: rd_word = {24'h00_0000, dig_base_q[NW-1:32]};
      fst_pkg::OFS_DIGNUM_LO: rd_word = digital_numerator[31:0];
      fst_pkg::OFS_DIGNUM_HI: rd_word = {24'h00_0000, digital_numerator[NW-1:32]};
      fst_pkg::OFS_ANANUM_LO: rd_word = analog_numerator[31:0];
      fst_pkg::OFS_ANANUM_HI: rd_word = {24'h00_0000, analog_numerator[NW-1:32]};
      fst_pkg::OFS_ANABASE_LO: rd_word = ana_base_q[31:0];
      fst_pkg::OFS_ANABASE_HI: rd_word = {24'h00_0000, ana_base_q[NW-1:32]};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // 40-bit words: low half staged, whole word commits on the high write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= fst_pkg::CTRL_RST;
      step_word_q <= '0;
      free_run_q <= '0;
      ana_base_q <= '0;
      lo_stage_q <= '0;
    end else if (wr_en) begin
      if (is_wr(ap_q, fst_pkg::OFS_CTRL)) begin
        ctrl_q <= hwdata[3:0];
      end
      if (is_wr(ap_q, fst_pkg::OFS_STEP_LO)) begin
        step_word_q[31:0] <= hwdata;
      end
      if (is_wr(ap_q, fst_pkg::OFS_STEP_HI)) begin
        step_word_q[SW-1:32] <= hwdata[SW-33:0];
      end
      if (is_wr(ap_q, fst_pkg::OFS_FREE_LO) || is_wr(ap_q, fst_pkg::OFS_FBNUM_LO) ||
          is_wr(ap_q, fst_pkg::OFS_ANABASE_LO)) begin
        lo_stage_q <= hwdata;
      end
      if (is_wr(ap_q, fst_pkg::OFS_FREE_HI)) begin
        free_run_q <= wr40;
      end
      if (is_wr(ap_q, fst_pkg::OFS_ANABASE_HI)) begin
        ana_base_q <= wr40;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_rel_q <= '0;
    end else if (wr_en && is_wr(ap_q, fst_pkg::OFS_FREE_HI) &&
                 ctrl_q[fst_pkg::CTRL_HIST_EN]) begin
      ana_rel_q <= ana_rel_q + wr40;
    end
  end

  // ************************************************************
  // channel state machine
  // ************************************************************
  logic hist_ok;

  assign hist_ok = ctrl_q[fst_pkg::CTRL_HIST_EN] && history_valid;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fst_pkg::FST_FREE_RUN: begin
        if (ref_valid) begin
          state_d = fst_pkg::FST_ACQUIRE;
        end
      end
      fst_pkg::FST_ACQUIRE: begin
        if (!ref_valid) begin
          state_d = fst_pkg::FST_HOLDOVER;
        end else if (acq_done) begin
          state_d = fst_pkg::FST_LOCKED;
        end
      end
      fst_pkg::FST_LOCKED: begin
        if (!ref_valid && ctrl_q[fst_pkg::CTRL_HIST_EN] && !history_valid) begin
          state_d = fst_pkg::FST_FREE_RUN;
        end else if (!ref_valid) begin
          state_d = fst_pkg::FST_HOLDOVER;
        end
      end
      fst_pkg::FST_HOLDOVER: begin
        if (ref_valid) begin
          state_d = fst_pkg::FST_ACQUIRE;
        end
      end
      default: state_d = fst_pkg::FST_FREE_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= fst_pkg::FST_FREE_RUN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wide_bw_active <= 1'b0;
      ref_selected <= 1'b0;
      analog_on_crystal <= 1'b0;
    end else if (ce) begin
      wide_bw_active <= (state_d == fst_pkg::FST_ACQUIRE);
      ref_selected <= (state_d == fst_pkg::FST_ACQUIRE) || (state_d == fst_pkg::FST_LOCKED);
      analog_on_crystal <= crystal_valid;
    end
  end

  // ************************************************************
  // lock flags and history
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_lock_lost_flag <= 1'b1;
      phase_lock_lost_flag <= 1'b1;
      history_accumulate <= 1'b0;
    end else if (ce) begin
      if (state_d != fst_pkg::FST_HOLDOVER) begin
        freq_lock_lost_flag <= !freq_in_tol;
      end
      phase_lock_lost_flag <= (state_d == fst_pkg::FST_HOLDOVER) || !phase_in_tol;
      history_accumulate <= ctrl_q[fst_pkg::CTRL_HIST_EN] &&
        (state_d == fst_pkg::FST_LOCKED) && freq_in_tol;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      holdover_freq_word <= '0;
    end else if (ce) begin
      holdover_freq_word <= hist_ok ? history_word : free_run_q;
    end
  end

  // ************************************************************
  // frequency steering
  // ************************************************************
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic closed_loop;
  fst_pkg::fst_step_t cmd;
  logic [NW-1:0] dig_off;
  logic [NW-1:0] ana_off;

  fst_pin_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .pin({steer_direction_pin, steer_trigger_pin}),
    .level(pin_level),
    .rise(pin_rise)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      steer_active_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl_q[fst_pkg::CTRL_STEER_EN]) begin
        steer_active_q <= 1'b0;
      end else if (state_q == fst_pkg::FST_LOCKED) begin
        steer_active_q <= 1'b1;
      end
    end
  end

  assign sw_step = wr_en && is_wr(ap_q, fst_pkg::OFS_UPDATE);
  assign fbnum_wr = wr_en && is_wr(ap_q, fst_pkg::OFS_FBNUM_HI);
  assign closed_loop = ctrl_q[fst_pkg::CTRL_DPLL_USED] &&
    ((state_q == fst_pkg::FST_ACQUIRE) || (state_q == fst_pkg::FST_LOCKED));

  always_comb begin
    cmd.step = 1'b0;
    cmd.dec = 1'b0;
    if (sw_step) begin
      cmd.step = steer_active_q;
      cmd.dec = hwdata[fst_pkg::UPD_DEC];
    end else if (ctrl_q[fst_pkg::CTRL_PIN_SEL] && pin_rise[0]) begin
      cmd.step = steer_active_q;
      cmd.dec = pin_level[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_base_q <= '0;
    end else if (fbnum_wr && !(steer_active_q && closed_loop)) begin
      dig_base_q <= wr40;
    end
  end

  fst_steer_acc #(
    .NUM_W(NW),
    .STEP_W(SW)
  ) u_dig_acc (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .clear(!steer_active_q),
    .load(fbnum_wr && closed_loop),
    .load_val(wr40 - dig_base_q),
    .step(cmd.step && closed_loop),
    .dec(cmd.dec),
    .step_word(step_word_q),
    .offset(dig_off)
  );

  fst_steer_acc #(
    .NUM_W(NW),
    .STEP_W(SW)
  ) u_ana_acc (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .clear(!steer_active_q),
    .load(1'b0),
    .load_val('0),
    .step(cmd.step && !closed_loop),
    .dec(cmd.dec),
    .step_word(step_word_q),
    .offset(ana_off)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      digital_numerator <= '0;
      analog_numerator <= '0;
    end else if (ce) begin
      digital_numerator <= dig_base_q + dig_off;
      analog_numerator <= ana_base_q + ana_off +
        (ctrl_q[fst_pkg::CTRL_HIST_EN] ? ana_rel_q : free_run_q);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_locked_loss;
    state_q == fst_pkg::FST_LOCKED && !ref_valid;
  endsequence

  sequence s_enter_hold;
    ce && state_q != fst_pkg::FST_HOLDOVER && state_d == fst_pkg::FST_HOLDOVER;
  endsequence

  free_unsel_a: assert property (state_q == fst_pkg::FST_FREE_RUN |->
    !ref_selected)
    else $error("reference selected in free-run");
  no_hist_free_a: assert property (ce and s_locked_loss and
    (ctrl_q[fst_pkg::CTRL_HIST_EN] && !history_valid) |=> state_q == fst_pkg::FST_FREE_RUN)
    else $error("expected free-run");
  acq_enter_a: assert property (ce && ref_valid &&
    (state_q == fst_pkg::FST_FREE_RUN || state_q == fst_pkg::FST_HOLDOVER) |=>
    state_q == fst_pkg::FST_ACQUIRE ##0 wide_bw_active)
    else $error("acquisition not entered");
  wide_bw_a: assert property (wide_bw_active == (state_q == fst_pkg::FST_ACQUIRE))
    else $error("bandwidth select mismatch");
  freq_track_a: assert property (ce && state_d != fst_pkg::FST_HOLDOVER |=>
    freq_lock_lost_flag == !$past(freq_in_tol))
    else $error("frequency flag not tracking");
  hist_acc_a: assert property (history_accumulate |->
    $past(ctrl_q[fst_pkg::CTRL_HIST_EN]) && state_q == fst_pkg::FST_LOCKED)
    else $error("history accumulating wrongly");
  hold_enter_a: assert property (ce and s_locked_loss and
    !(ctrl_q[fst_pkg::CTRL_HIST_EN] && !history_valid) |=> state_q == fst_pkg::FST_HOLDOVER)
    else $error("holdover not entered");
  hold_word_a: assert property (ce && !hist_ok |=>
    holdover_freq_word == $past(free_run_q))
    else $error("free-run word not used");
  hist_word_a: assert property (ce && hist_ok |=>
    holdover_freq_word == $past(history_word))
    else $error("history word not used");
  phase_set_a: assert property (s_enter_hold |=> phase_lock_lost_flag)
    else $error("phase flag not set in holdover");
  freq_frozen_a: assert property (ce && state_q == fst_pkg::FST_HOLDOVER &&
    state_d == fst_pkg::FST_HOLDOVER |=> $stable(freq_lock_lost_flag))
    else $error("frequency flag moved in holdover");
  steer_route_a: assert property (ce && cmd.step && !closed_loop && steer_active_q |=>
    $stable(dig_off))
    else $error("open loop step hit digital");
  steer_gate_a: assert property (ce && !steer_active_q &&
    state_q != fst_pkg::FST_LOCKED |=> !steer_active_q)
    else $error("steering enabled outside lock");
  sw_dec_a: assert property (sw_step |-> cmd.dec == hwdata[fst_pkg::UPD_DEC])
    else $error("update bit sign wrong");
  pin_dir_a: assert property (!sw_step && ctrl_q[fst_pkg::CTRL_PIN_SEL] && pin_rise[0] &&
    steer_active_q |-> cmd.step && cmd.dec == pin_level[1])
    else $error("pin step wrong");
  clr_restore_a: assert property (ce && !steer_active_q ##1 ce |=>
    digital_numerator == $past(dig_base_q))
    else $error("numerator not restored");

endmodule

// ---- verilog/fst_pkg.sv ----
// Purpose: shared constants and types for the pll channel state and steering control
// Assumes: 40 MHz hclk, AHB-Lite register access, one aligned word per register
// Notes: byte offsets below are the register byte addresses

package fst_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned NUM_W = 40;
  localparam int unsigned STEP_W = 38;
  localparam int unsigned AW = 8;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_STEP_LO = 8'h08;
  localparam logic [AW-1:0] OFS_STEP_HI = 8'h0c;
  localparam logic [AW-1:0] OFS_FREE_LO = 8'h10;
  localparam logic [AW-1:0] OFS_FREE_HI = 8'h14;
  localparam logic [AW-1:0] OFS_FBNUM_LO = 8'h18;
  localparam logic [AW-1:0] OFS_FBNUM_HI = 8'h1c;
  localparam logic [AW-1:0] OFS_UPDATE = 8'h20;
  localparam logic [AW-1:0] OFS_DIGNUM_LO = 8'h24;
  localparam logic [AW-1:0] OFS_DIGNUM_HI = 8'h28;
  localparam logic [AW-1:0] OFS_ANANUM_LO = 8'h2c;
  localparam logic [AW-1:0] OFS_ANANUM_HI = 8'h30;
  localparam logic [AW-1:0] OFS_ANABASE_LO = 8'h34;
  localparam logic [AW-1:0] OFS_ANABASE_HI = 8'h38;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int unsigned CTRL_HIST_EN = 0;
  localparam int unsigned CTRL_STEER_EN = 1;
  localparam int unsigned CTRL_PIN_SEL = 2;
  localparam int unsigned CTRL_DPLL_USED = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;
  localparam int unsigned UPD_DEC = 0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_FREQ_LOST = 4;
  localparam int unsigned ST_PHASE_LOST = 5;
  localparam int unsigned ST_WIDE_BW = 6;
  localparam int unsigned ST_HIST_ACC = 7;
  localparam int unsigned ST_STEER_ACT = 8;
  localparam int unsigned ST_REF_SEL = 9;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned TRIG_MIN_HIGH_NS = 100;
  localparam int unsigned TRIG_MIN_HIGH_CYC = (TRIG_MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_RATE_MAX_KHZ = 5000;
  localparam int unsigned STEP_MIN_PERIOD_CYC = (CLK_MHZ * 1000 + STEP_RATE_MAX_KHZ - 1)
    / STEP_RATE_MAX_KHZ;
  localparam int unsigned SYNC_STAGES = 3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    FST_FREE_RUN = 4'b0001,
    FST_ACQUIRE = 4'b0010,
    FST_LOCKED = 4'b0100,
    FST_HOLDOVER = 4'b1000
  } fst_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [AW-1:0] addr;
  } fst_ahb_ap_t;

  typedef struct packed {
    logic step;
    logic dec;
  } fst_step_t;

endpackage

// ---- verilog/fst_pin_sync.sv ----
// Purpose: bring the steering trigger and direction pins into the hclk domain
// Assumes: pins are asynchronous to hclk
// Notes: a level is accepted once stages two and three agree

module fst_pin_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        level[i] <= 1'b0;
        rise[i] <= 1'b0;
      end else if (ce) begin
        rise[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level[i];
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ---- verilog/fst_steer_acc.sv ----
// Purpose: accumulated frequency offset for one loop numerator
// Assumes: clear has priority over load, load over step
// Notes: the offset is unsigned modulo 2**NUM_W

module fst_steer_acc #(
  parameter int unsigned NUM_W = 40,
  parameter int unsigned STEP_W = 38
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic load,
  input wire logic [NUM_W-1:0] load_val,
  input wire logic step,
  input wire logic dec,
  input wire logic [STEP_W-1:0] step_word,
  output logic [NUM_W-1:0] offset
);

  logic [NUM_W-1:0] step_ext;

  assign step_ext = {{(NUM_W - STEP_W){1'b0}}, step_word};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset <= '0;
    end else if (ce) begin
      if (clear) begin
        offset <= '0;
      end else if (load) begin
        offset <= load_val;
      end else if (step) begin
        offset <= dec ? offset - step_ext : offset + step_ext;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  clear_zero_a: assert property (ce && clear |=> offset == '0)
    else $error("offset not cleared");
  step_add_a: assert property (ce && step && !dec && !clear && !load |=>
    offset == $past(offset) + $past(step_ext))
    else $error("increment step wrong");
  step_sub_a: assert property (ce && step && dec && !clear && !load |=>
    offset == $past(offset) - $past(step_ext))
    else $error("decrement step wrong");

endmodule

// ---- dv/fst_far_model.sv ----
// Purpose: reference side and external steering logic
// Assumes: driven from the bench by task calls
// Notes: detectors drop out two cycles after the reference goes
module fst_far_model (
  input wire logic clk,
  output logic ref_valid,
  output logic acq_done,
  output logic freq_in_tol,
  output logic phase_in_tol,
  output logic trig,
  output logic dir
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {ref_valid, acq_done, freq_in_tol, phase_in_tol, trig, dir} = 6'h0;
  task automatic link(input logic v);
    @(posedge clk);
    ref_valid <= v;
    if (!v) begin
      repeat (2) @(posedge clk);
      {acq_done, freq_in_tol, phase_in_tol} <= 3'h0;
    end
  endtask
  task automatic lock();
    @(posedge clk);
    {acq_done, freq_in_tol, phase_in_tol} <= 3'h7;
  endtask
  task automatic step(input logic d);
    @(posedge clk);
    dir <= d;
    trig <= 1'b1;
    repeat (5) @(posedge clk);
    trig <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ---- dv/dpll_state_and_freq_steering_tb.sv ----
// Purpose: self-checking bench for the channel state and steering block
// Assumes: zero wait state slave, hready looped back
// Notes: seed fixed, step word and numerators random
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dpll_state_and_freq_steering_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic ce = 1, cv = 1, hv = 0;
  logic [39:0] hwd = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, rv, ad, ft, pt, tp, dp, fl, pl, wb, ha, rs, ac;
  logic [39:0] hw, dn, an, base, num, fw;
  logic [37:0] sw;
  int fail_count = 0, n_checks = 0;
  always #12.5 hclk = ~hclk;
  fst_far_model i_far (.clk(hclk), .ref_valid(rv), .acq_done(ad), .freq_in_tol(ft),
    .phase_in_tol(pt), .trig(tp), .dir(dp));
  fst_dpll_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ref_valid(rv), .crystal_valid(cv), .acq_done(ad), .freq_in_tol(ft),
    .phase_in_tol(pt), .history_valid(hv), .history_word(hwd),
    .steer_trigger_pin(tp), .steer_direction_pin(dp), .freq_lock_lost_flag(fl),
    .phase_lock_lost_flag(pl), .wide_bw_active(wb), .history_accumulate(ha),
    .ref_selected(rs), .analog_on_crystal(ac), .holdover_freq_word(hw),
    .digital_numerator(dn), .analog_numerator(an));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [39:0] stepped(logic [39:0] b, logic [37:0] s, logic d);
    return d ? b - {2'h0, s} : b + {2'h0, s};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(72189));
    sw = 38'({$urandom, $urandom});
    base = 40'({$urandom, $urandom});
    fw = 40'({$urandom, $urandom});
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, fst_pkg::OFS_STATUS, 0);
    `CHK("status", 7'h31, {hresp, rd[5:0]})
    i_far.link(1);
    repeat (3) @(posedge hclk);
    `CHK("acquire", 2'h3, {wb, rs})
    i_far.lock();
    repeat (3) @(posedge hclk);
    `CHK("locked", 4'h4, {wb, rs, fl, pl})
    xfer(1, fst_pkg::OFS_FBNUM_LO, base[31:0]);
    xfer(1, fst_pkg::OFS_FBNUM_HI, {24'h0, base[39:32]});
    xfer(1, fst_pkg::OFS_STEP_LO, sw[31:0]);
    xfer(1, fst_pkg::OFS_STEP_HI, {26'h0, sw[37:32]});
    xfer(1, fst_pkg::OFS_FREE_LO, fw[31:0]);
    xfer(1, fst_pkg::OFS_FREE_HI, {24'h0, fw[39:32]});
    xfer(1, fst_pkg::OFS_CTRL, 32'he);
    num = base;
    for (int i = 0; i < 6; i++) begin
      if (i[0]) i_far.step(i[1]);
      else xfer(1, fst_pkg::OFS_UPDATE, {31'h0, i[1]});
      num = stepped(num, sw, i[1]);
      repeat (8) @(posedge hclk);
      `CHK("dig num", num, dn)
    end
    xfer(0, fst_pkg::OFS_DIGNUM_LO, 0);
    `CHK("dig num reg", num[31:0], rd)
    xfer(1, fst_pkg::OFS_CTRL, 32'h8);
    repeat (4) @(posedge hclk);
    `CHK("restored", base, dn)
    xfer(1, fst_pkg::OFS_CTRL, 32'h2);
    xfer(1, fst_pkg::OFS_UPDATE, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK("ana step", {stepped(fw, sw, 1'b0), base}, {an, dn})
    i_far.link(0);
    repeat (4) @(posedge hclk);
    `CHK("holdover", {3'h4, fw}, {pl, rs, fl, hw})
    xfer(0, fst_pkg::OFS_STATUS, 0);
    `CHK("hold state", 4'h8, rd[3:0])
    i_far.link(1);
    repeat (3) @(posedge hclk);
    `CHK("reacquire", 2'h3, {wb, rs})
    ce <= 1'b0;
    i_far.lock();
    repeat (3) @(posedge hclk);
    `CHK("frozen", 2'h3, {wb, rs})
    ce <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK("relocked", 4'h4, {wb, rs, fl, pl})
    xfer(1, fst_pkg::OFS_CTRL, 32'h1);
    hv <= 1'b1;
    hwd <= 40'({$urandom, $urandom});
    cv <= 1'($urandom);
    repeat (4) @(posedge hclk);
    `CHK("history", {1'b1, hwd, 40'h0}, {ha, hw, an})
    `CHK("crystal", cv, ac)
    hv <= 1'b0;
    i_far.link(0);
    xfer(0, fst_pkg::OFS_STATUS, 0);
    `CHK("no history", 4'h1, rd[3:0])
    report_and_stop();
  end
endmodule
